// ### rtl/vam_pkg.sv
// Summary of operation
// - Asymmetry is the negative sequence part of the three phase-to-phase voltages.
// - Monitor runs only with three-phase four-wire or three-wire measuring wiring.
// - Limit is 0.5 to 99.9 percent of nominal delta voltage, default 10.0.
// - Trip needs asymmetry at or above the limit without break for the delay; the code keeps timing while it stays above limit minus hysteresis.
// - Delay is 0.02 to 99.99 seconds, default 5.00 seconds.
// - Falling below limit minus hysteresis before expiry clears the delay timer.
// - A trip raises the alarm indication and the monitor's logic command flag.
// - Monitoring enable, on by default, gates all evaluation and tripping.
// - One alarm class, A to F or Control, is chosen and reported with trip.
// - With self-acknowledge on, the alarm clears once the fault is gone.
// - With self-acknowledge off, alarm holds until operator or external acknowledge.
// - When lockable, faults are evaluated only while the lock status is false.
package vam_pkg;

    // Clock and delay tick timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 10000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PRESC_W = 18;

    // Limit in units of 0.1 percent and delay in 10 ms ticks.
    localparam logic [9:0] LIMIT_MIN = 10'h005;
    localparam logic [9:0] LIMIT_MAX = 10'h3e7;
    localparam logic [9:0] LIMIT_DEFAULT = 10'h064;
    localparam logic [13:0] DELAY_MIN = 14'h0002;
    localparam logic [13:0] DELAY_MAX = 14'h270f;
    localparam logic [13:0] DELAY_DEFAULT = 14'h01f4;
    localparam logic [9:0] HYST_PERMILLE = 10'h005;
    localparam logic [63:0] PCT_SCALE_SQ = 64'h00000000000f4240;
    localparam logic [63:0] SEQ_SCALE = 64'h0000000000000003;

    // Fixed-point rotation constants in Q15.
    localparam int Q_SHIFT = 15;
    localparam logic signed [16:0] K_ONE = 17'sh08000;
    localparam logic signed [16:0] K_HALF = 17'sh04000;
    localparam logic signed [16:0] K_SQRT3_HALF = 17'sh06eda;

    // Reset values.
    localparam logic [13:0] TIMER_RESET = 14'h0000;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 18'h00000;

    typedef enum logic [1:0] {
        VAM_THREE_PHASE_FOUR_WIRE = 2'h0,
        VAM_THREE_PHASE_THREE_WIRE = 2'h1,
        VAM_ONE_PHASE_TWO_WIRE = 2'h2,
        VAM_ONE_PHASE_THREE_WIRE = 2'h3
    } vam_wiring_e;

    typedef enum logic [2:0] {
        VAM_CLASS_A = 3'h0,
        VAM_CLASS_B = 3'h1,
        VAM_CLASS_C = 3'h2,
        VAM_CLASS_D = 3'h3,
        VAM_CLASS_E = 3'h4,
        VAM_CLASS_F = 3'h5,
        VAM_CLASS_CONTROL = 3'h6
    } vam_class_e;

    localparam vam_class_e CLASS_RESET = VAM_CLASS_A;

    typedef enum logic [2:0] {
        VAM_IDLE = 3'h1,
        VAM_PEND = 3'h2,
        VAM_TRIP = 3'h4
    } vam_state_e;

    typedef struct packed {
        logic signed [15:0] re;
        logic signed [15:0] im;
    } vam_phasor_s;

    typedef struct packed {
        logic valid;
        vam_phasor_s uv_ab;
        vam_phasor_s uv_bc;
        vam_phasor_s uv_ca;
    } vam_sample_s;

    typedef struct packed {
        logic enable;
        vam_wiring_e wiring;
        logic [9:0] limit;
        logic [13:0] delay;
        vam_class_e alarm_class;
        logic self_ack;
        logic lockable;
    } vam_cfg_s;

    typedef struct packed {
        logic asymmetry_alarm_text;
        logic logic_flag;
        vam_class_e alarm_class;
        logic pending;
        logic tripped;
    } vam_status_s;

    // Signed phasor component times a Q15 constant.
    function automatic logic signed [35:0] mul_k(input logic signed [15:0] v, input logic signed [16:0] k);
        mul_k = 36'(v) * 36'(k);
    endfunction

    // Keeps a setting inside its legal range.
    function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo, input logic [13:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

endpackage

// ### rtl/vam_neg_seq.sv
`timescale 1ns/1ps
module vam_neg_seq import vam_pkg::*; (
    // Clock, enable and reset.
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic sys_rst,
    // Measured phasors and scaling.
    input wire vam_sample_s sample,
    input wire logic [15:0] nominal,
    input wire logic [9:0] limit,
    // Comparison results.
    output logic result_valid,
    output logic above_limit,
    output logic below_release
);

    logic signed [35:0] re3;
    logic signed [35:0] im3;
    logic signed [63:0] re_w;
    logic signed [63:0] im_w;
    logic [63:0] lhs;
    logic [63:0] lim_v;
    logic [63:0] rel_v;
    logic [9:0] rel_pct;
    logic valid_reg;
    logic valid_next;
    logic above_reg;
    logic above_next;
    logic below_reg;
    logic below_next;

    // Three times the negative sequence phasor: ab + a^2 * bc + a * ca, then squared magnitude scaled.
    always_comb begin
        re3 = mul_k(sample.uv_ab.re, K_ONE) - mul_k(sample.uv_bc.re, K_HALF)
            + mul_k(sample.uv_bc.im, K_SQRT3_HALF) - mul_k(sample.uv_ca.re, K_HALF)
            - mul_k(sample.uv_ca.im, K_SQRT3_HALF);
        im3 = mul_k(sample.uv_ab.im, K_ONE) - mul_k(sample.uv_bc.re, K_SQRT3_HALF)
            - mul_k(sample.uv_bc.im, K_HALF) + mul_k(sample.uv_ca.re, K_SQRT3_HALF)
            - mul_k(sample.uv_ca.im, K_HALF);
        re_w = 64'(re3) >>> Q_SHIFT;
        im_w = 64'(im3) >>> Q_SHIFT;
        lhs = 64'(re_w * re_w + im_w * im_w) * PCT_SCALE_SQ;
        rel_pct = (limit > HYST_PERMILLE) ? 10'(limit - HYST_PERMILLE) : 10'h000;
        lim_v = 64'(limit) * SEQ_SCALE * 64'(nominal);
        rel_v = 64'(rel_pct) * SEQ_SCALE * 64'(nominal);
        valid_next = sample.valid;
        above_next = above_reg;
        below_next = below_reg;
        if (sample.valid) begin
            above_next = lhs >= lim_v * lim_v;
            below_next = lhs < rel_v * rel_v;
        end
    end

    // Result registers; the comparisons are updated only on a new sample, the valid flag every cycle.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            valid_reg <= 1'b0;
            above_reg <= 1'b0;
            below_reg <= 1'b1;
        end else if (ce) begin
            valid_reg <= valid_next;
            above_reg <= above_next;
            below_reg <= below_next;
        end
    end

    assign result_valid = valid_reg;
    assign above_limit = above_reg;
    assign below_release = below_reg;

endmodule

// ### rtl/vam_monitor.sv
`timescale 1ns/1ps
module vam_monitor import vam_pkg::*; #(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock, enable and reset.
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic sys_rst,
    // Measurement front end.
    input wire vam_sample_s sample,
    input wire logic [15:0] nominal_uv,
    // Settings and lock.
    input wire vam_cfg_s cfg,
    input wire logic lock_status,
    // Acknowledge sources.
    input wire logic operator_ack,
    input wire logic ext_ack_pin,
    // Alarm outputs.
    output vam_status_s status
);

    // Registered state and its next values.
    vam_state_e state_reg;
    vam_state_e state_next;
    logic [13:0] timer_reg;
    logic [13:0] timer_next;
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic alarm_reg;
    logic alarm_next;
    vam_class_e class_reg;
    vam_class_e class_next;
    logic over_reg;
    logic over_next;
    logic under_reg;
    logic under_next;
    logic ack_sync1_reg;
    logic ack_sync2_reg;

    // Comparison results and decoded conditions.
    logic res_valid;
    logic res_above;
    logic res_below;
    logic wiring_ok;
    logic active;
    logic tick;
    logic trip_enter;
    logic ack_any;
    logic [9:0] limit_eff;
    logic [13:0] delay_eff;

    // Negative sequence evaluation of each new sample.
    vam_neg_seq u_neg_seq (
        .clk_sys(clk_sys),
        .ce(ce),
        .sys_rst(sys_rst),
        .sample(sample),
        .nominal(nominal_uv),
        .limit(limit_eff),
        .result_valid(res_valid),
        .above_limit(res_above),
        .below_release(res_below)
    );

    // The external acknowledge is a discrete pin and is synchronised first.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_sync1_reg <= 1'b0;
            ack_sync2_reg <= 1'b0;
        end else if (ce) begin
            ack_sync1_reg <= ext_ack_pin;
            ack_sync2_reg <= ack_sync1_reg;
        end
    end

    // Activity gating and settings kept in range.
    assign limit_eff = 10'(clamp(14'(cfg.limit), 14'(LIMIT_MIN), 14'(LIMIT_MAX)));
    assign delay_eff = clamp(cfg.delay, DELAY_MIN, DELAY_MAX);
    assign wiring_ok = (cfg.wiring == VAM_THREE_PHASE_FOUR_WIRE) || (cfg.wiring == VAM_THREE_PHASE_THREE_WIRE);
    assign active = cfg.enable && wiring_ok && !(cfg.lockable && lock_status);
    assign tick = (presc_reg == PRESC_W'(TICK_LEN - 1));

    // Either acknowledge source, operator or synchronised pin, may release a held alarm.
    assign ack_any = operator_ack || ack_sync2_reg;
    assign trip_enter = (state_reg == VAM_PEND) && (state_next == VAM_TRIP);

    // Delay timer, trip state, latched comparison and alarm.
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        presc_next = presc_reg;
        over_next = over_reg;
        under_next = under_reg;
        class_next = class_reg;
        alarm_next = alarm_reg;
        // A comparison result replaces the latched one only when it belongs to a new sample.
        if (res_valid) begin
            over_next = res_above;
            under_next = res_below;
        end
        // Going inactive forces a clean restart of the delay and the comparison.
        if (!active) begin
            state_next = VAM_IDLE;
            timer_next = TIMER_RESET;
            presc_next = PRESC_RESET;
            over_next = 1'b0;
            under_next = 1'b1;
        end else begin
            unique case (state_reg)
                VAM_IDLE: begin
                    timer_next = TIMER_RESET;
                    presc_next = PRESC_RESET;
                    if (over_reg) begin
                        state_next = VAM_PEND;
                    end
                end
                VAM_PEND: begin
                    if (under_reg) begin
                        state_next = VAM_IDLE;
                        timer_next = TIMER_RESET;
                        presc_next = PRESC_RESET;
                    end else if (tick) begin
                        presc_next = PRESC_RESET;
                        timer_next = timer_reg + 14'h0001;
                        if (timer_reg + 14'h0001 >= delay_eff) begin
                            state_next = VAM_TRIP;
                        end
                    end else begin
                        presc_next = presc_reg + PRESC_W'(1);
                    end
                end
                VAM_TRIP: begin
                    if (under_reg) begin
                        state_next = VAM_IDLE;
                        timer_next = TIMER_RESET;
                    end
                end
            endcase
        end
        // Self-acknowledge follows the fault state; manual mode waits for an acknowledge.
        if (cfg.self_ack) begin
            alarm_next = (state_next == VAM_TRIP);
        end else if (ack_any && state_next != VAM_TRIP) begin
            alarm_next = 1'b0;
        end
        // A trip entry wins over an acknowledge in the same cycle.
        if (state_reg == VAM_PEND && state_next == VAM_TRIP) begin
            alarm_next = 1'b1;
            class_next = cfg.alarm_class;
        end
    end

    // Registers every group of state except the acknowledge synchroniser; a low clock enable freezes all of it.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= VAM_IDLE;
            timer_reg <= TIMER_RESET;
            presc_reg <= PRESC_RESET;
            over_reg <= 1'b0;
            under_reg <= 1'b1;
            class_reg <= CLASS_RESET;
            alarm_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            presc_reg <= presc_next;
            over_reg <= over_next;
            under_reg <= under_next;
            class_reg <= class_next;
            alarm_reg <= alarm_next;
        end
    end

    // Display indication and logic flag both follow the latched alarm.
    assign status.asymmetry_alarm_text = alarm_reg;
    assign status.logic_flag = alarm_reg;
    assign status.alarm_class = class_reg;
    assign status.pending = (state_reg == VAM_PEND);
    assign status.tripped = (state_reg == VAM_TRIP);

    // Checks on the monitor's behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    disabled_idle_a: assert property (ce && !cfg.enable
        |=> state_reg == VAM_IDLE && timer_reg == TIMER_RESET)
        else $error("Disabled monitor left idle.");
    wiring_gate_a: assert property (ce && !wiring_ok |=> state_reg == VAM_IDLE)
        else $error("Monitor ran with single-phase wiring.");
    lock_gate_a: assert property (ce && cfg.lockable && lock_status |=> state_reg == VAM_IDLE && !over_reg)
        else $error("Locked monitor kept evaluating.");
    inactive_clear_a: assert property (ce && !active && cfg.self_ack
        |=> !alarm_reg && timer_reg == TIMER_RESET)
        else $error("Inactive monitor kept timer or alarm.");
    hyst_reset_a: assert property (ce && active && state_reg == VAM_PEND && under_reg
        |=> timer_reg == TIMER_RESET)
        else $error("Timer not cleared below hysteresis.");
    trip_delay_a: assert property (ce && trip_enter |-> tick && active && !under_reg
        && timer_reg + 14'h0001 >= delay_eff)
        else $error("Trip before delay elapsed.");
    trip_alarm_a: assert property (ce && trip_enter
        |=> alarm_reg && status.logic_flag && state_reg == VAM_TRIP)
        else $error("Trip did not raise alarm.");
    class_report_a: assert property ($rose(alarm_reg) |-> class_reg == $past(cfg.alarm_class))
        else $error("Reported alarm class differs from setting.");
    self_ack_a: assert property (ce && cfg.self_ack |=> alarm_reg == (state_reg == VAM_TRIP))
        else $error("Self-acknowledged alarm not following fault.");
    manual_hold_a: assert property (ce && !cfg.self_ack && alarm_reg && !ack_any |=> alarm_reg)
        else $error("Manual alarm dropped without acknowledge.");
    tick_count_a: assert property (ce && state_reg == VAM_PEND && !under_reg && active && !tick
        |=> timer_reg == $past(timer_reg))
        else $error("Timer advanced between ticks.");
    ce_freeze_a: assert property (!ce |=> $stable(state_reg) && $stable(timer_reg) && $stable(alarm_reg))
        else $error("State moved while clock enable was low.");
    class_hold_a: assert property (ce && !trip_enter |=> $stable(class_reg))
        else $error("Reported class changed without a trip.");
    manual_ack_a: assert property (ce && active && !cfg.self_ack && ack_any && state_reg == VAM_IDLE
        |=> !alarm_reg)
        else $error("Acknowledge did not clear the held alarm.");
    inactive_out_a: assert property (ce && !active |=> !status.pending && !status.tripped)
        else $error("Inactive monitor still pending or tripped.");

    trip_seen_c: cover property (ce && trip_enter);
    hyst_seen_c: cover property (ce && state_reg == VAM_PEND && under_reg && active);
    manual_ack_c: cover property (!cfg.self_ack && alarm_reg ##1 !alarm_reg);
    lock_seen_c: cover property (cfg.lockable && lock_status && over_reg);
    freeze_seen_c: cover property (!ce && state_reg == VAM_PEND);

endmodule

// ### tb/vam_front_end.sv
`timescale 1ns/1ps
module vam_front_end import vam_pkg::*; #(
    parameter int GAP = 3
) (
    // Clock and wanted difference level.
    input wire logic clk_sys,
    input wire logic [15:0] amp,
    // Phasor stream towards the monitor.
    output vam_sample_s sample
);
    int cnt = 0;
    vam_sample_s smp = '0;

    // Emits one sample every GAP cycles; between them the data lines toggle so stale values are never trusted.
    always @(negedge clk_sys) begin
        cnt = (cnt + 1) % GAP;
        if (cnt == 0) begin
            smp.valid = 1'b1;
            smp.uv_ab.re = amp;
            smp.uv_ab.im = 16'sh0000;
            smp.uv_bc = '0;
            smp.uv_ca = '0;
        end else begin
            smp = {1'b0, ~smp[95:0]};
        end
    end

    // Starts quiet so the monitor sees no stray sample at time zero.
    assign sample = smp;
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import vam_pkg::*;
    localparam int TL = 4;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] amp = 16'h0000;
    logic lock_status = 1'b0;
    logic operator_ack = 1'b0;
    logic ext_ack_pin = 1'b0;
    logic ce = 1'b1;
    logic [15:0] nominal = 16'h03e8;
    vam_cfg_s cfg = '0;
    vam_sample_s sample;
    vam_status_s status;
    int error_cnt = 0;
    int tests_run = 0;

    // System clock at 25 MHz.
    always #20 clk_sys = ~clk_sys;

    // Front end model and the monitor under test; nominal level starts at 1000 units.
    vam_front_end #(.GAP(3)) vam_front_end_i (.clk_sys(clk_sys), .amp(amp), .sample(sample));
    vam_monitor #(.TICK_LEN(TL)) vam_monitor_i (.clk_sys(clk_sys), .ce(ce), .sys_rst(sys_rst),
        .sample(sample), .nominal_uv(nominal), .cfg(cfg), .lock_status(lock_status),
        .operator_ack(operator_ack), .ext_ack_pin(ext_ack_pin), .status(status));

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compares one status bit.
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Compares the reported alarm class.
    task automatic chk_cls(input vam_class_e got, input vam_class_e exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t class: got %h expected %h", $time, got, exp);
        end
    endtask

    // Lets n falling edges pass; inputs change only there.
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Applies a level and waits a bounded time for the trip; a missed trip ends the run.
    task automatic expect_trip(input logic [15:0] a, input int lo, input int hi, input logic exp);
        int used;
        used = 0;
        amp = a;
        while (status.tripped !== 1'b1 && used < hi) begin
            cycles(1);
            used++;
        end
        chk_bit(status.tripped, exp, "trip state");
        if (exp) begin
            chk_bit(used >= lo, 1'b1, "trip too early");
            if (status.tripped !== 1'b1) begin
                conclude();
            end
        end
    endtask

    // Removes the fault and gives time for the alarm to settle.
    task automatic quiet();
        amp = 16'h0000;
        cycles(8);
    endtask

    // Cuts a hung run short.
    initial begin
        cycles(20000);
        error_cnt++;
        $display("ERROR %0t run did not finish", $time);
        conclude();
    end

    // Main sequence.
    initial begin
        cfg = '{enable: 1'b1, wiring: VAM_THREE_PHASE_FOUR_WIRE, limit: 10'h064, delay: 14'h0000,
            alarm_class: VAM_CLASS_A, self_ack: 1'b1, lockable: 1'b0};
        cycles(2);
        sys_rst = 1'b0;
        cycles(1);
        chk_bit(status.asymmetry_alarm_text, 1'b0, "reset alarm");
        chk_bit(status.logic_flag, 1'b0, "reset flag");
        chk_cls(status.alarm_class, VAM_CLASS_A);
        // Every class, both three-phase wirings, level exactly at the limit, zero delay clamped to two ticks.
        for (int c = 0; c < 7; c++) begin
            cfg.alarm_class = vam_class_e'(c);
            cfg.wiring = vam_wiring_e'(c % 2);
            expect_trip(16'h012c, 2 * TL, 2 * TL + 14, 1'b1);
            chk_bit(status.asymmetry_alarm_text, 1'b1, "alarm");
            chk_bit(status.logic_flag, 1'b1, "flag");
            chk_cls(status.alarm_class, vam_class_e'(c));
            quiet();
            chk_bit(status.asymmetry_alarm_text, 1'b0, "self clear");
        end
        // Just below the limit never trips.
        cfg.delay = 14'h0005;
        expect_trip(16'h012b, 0, 40, 1'b0);
        // A dip below the release level restarts the delay.
        amp = 16'h012c;
        cycles(14);
        chk_bit(status.pending, 1'b1, "delay running");
        amp = 16'h0118;
        cycles(6);
        chk_bit(status.pending, 1'b0, "delay restarted");
        expect_trip(16'h012c, 5 * TL, 5 * TL + 14, 1'b1);
        quiet();
        // A dip inside the hysteresis band keeps counting and keeps the alarm.
        amp = 16'h012c;
        cycles(10);
        expect_trip(16'h0122, 5 * TL - 10, 5 * TL + 14, 1'b1);
        cycles(8);
        chk_bit(status.asymmetry_alarm_text, 1'b1, "band holds");
        quiet();
        // A low clock enable freezes the delay, which then resumes where it stopped.
        amp = 16'h012c;
        cycles(10);
        ce = 1'b0;
        cycles(30);
        chk_bit(status.pending, 1'b1, "frozen pending");
        chk_bit(status.tripped, 1'b0, "frozen trip");
        ce = 1'b1;
        expect_trip(16'h012c, 5 * TL - 10, 5 * TL + 14, 1'b1);
        quiet();
        // Manual mode: alarm held until operator, then external, acknowledge.
        cfg.self_ack = 1'b0;
        for (int k = 0; k < 2; k++) begin
            expect_trip(16'h012c, 5 * TL, 5 * TL + 14, 1'b1);
            operator_ack = 1'b1;
            cycles(1);
            operator_ack = 1'b0;
            quiet();
            chk_bit(status.asymmetry_alarm_text, 1'b1, "held");
            operator_ack = (k == 0);
            ext_ack_pin = (k == 1);
            cycles(2);
            operator_ack = 1'b0;
            ext_ack_pin = 1'b0;
            cycles(4);
            chk_bit(status.asymmetry_alarm_text, 1'b0, "acknowledged");
        end
        // Each way of going inactive clears the trip and blocks a new one.
        cfg.self_ack = 1'b1;
        for (int k = 0; k < 4; k++) begin
            expect_trip(16'h012c, 5 * TL, 5 * TL + 14, 1'b1);
            cfg.enable = (k != 0);
            cfg.wiring = (k == 1) ? VAM_ONE_PHASE_TWO_WIRE : (k == 2) ? VAM_ONE_PHASE_THREE_WIRE : cfg.wiring;
            cfg.lockable = (k == 3);
            lock_status = (k == 3);
            cycles(3);
            chk_bit(status.tripped, 1'b0, "inactive trip");
            chk_bit(status.asymmetry_alarm_text, 1'b0, "inactive alarm");
            expect_trip(16'h012c, 0, 40, 1'b0);
            cfg.enable = 1'b1;
            cfg.wiring = VAM_THREE_PHASE_THREE_WIRE;
            cfg.lockable = 1'b0;
            quiet();
        end
        // Lock input is ignored unless the monitor is lockable.
        expect_trip(16'h012c, 5 * TL, 5 * TL + 14, 1'b1);
        chk_cls(status.alarm_class, VAM_CLASS_CONTROL);
        // A reset in mid-run drops the trip and the reported class.
        sys_rst = 1'b1;
        cycles(2);
        sys_rst = 1'b0;
        cycles(1);
        chk_bit(status.tripped, 1'b0, "rerun trip");
        chk_bit(status.asymmetry_alarm_text, 1'b0, "rerun alarm");
        chk_cls(status.alarm_class, VAM_CLASS_A);
        quiet();
        // Lowest limit of 0.5 percent reached by clamping a zero setting.
        cfg.limit = 10'h000;
        expect_trip(16'h000e, 0, 40, 1'b0);
        expect_trip(16'h000f, 5 * TL, 5 * TL + 14, 1'b1);
        // A doubled nominal level doubles the level that trips.
        cfg.limit = 10'h064;
        nominal = 16'h07d0;
        quiet();
        expect_trip(16'h0257, 0, 40, 1'b0);
        expect_trip(16'h0258, 5 * TL, 5 * TL + 14, 1'b1);
        conclude();
    end
endmodule
